// >>> rtl/rco_refclk_out.sv
/*
 * Reference clock output: AHB-Lite control register, run state and pin driver.
 * Assumes base clock edges arrive as ticks on hclk and a single AHB-Lite master.
 */
`timescale 1ns/1ps

module rco_refclk_out (
	input  logic                   hclk,
	input  logic                   hresetn,
	input  logic                   hsel,
	input  logic [31:0]            haddr,
	input  logic [1:0]             htrans,
	input  logic                   hwrite,
	input  logic [2:0]             hsize,
	input  logic [31:0]            hwdata,
	input  logic                   hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  logic                   sleep_mode,
	input  rco_pkg::rco_osc_mode_t primary_osc_mode,
	input  logic                   primary_osc_tick,
	input  logic                   system_clk_tick,
	output logic                   reference_clock_pin,
	output logic                   reference_clock_pin_oe,
	output logic                   primary_osc_power_down
);
	import rco_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RCO_REG_W-1:0] ctrl;
		logic                 dp_write;
		logic                 dp_ctrl;
		logic [31:0]          rdata;
		rco_state_t           fsm;
		logic                 pin;
		logic                 pin_oe;
	} rco_main_t;

	rco_main_t              st_reg;
	rco_main_t              st_next;
	logic                   addr_phase;
	logic                   ctrl_wr;
	logic                   ctrl_en;
	logic                   ctrl_slp;
	logic                   ctrl_sel;
	logic [RCO_DIV_W-1:0]   divisor;
	logic [RCO_DIV_W-1:0]   wr_div;
	logic                   base_tick;
	logic                   sleep_allowed;
	logic                   running;
	logic                   div_out;
	logic [RCO_STAT_W-1:0]  status;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	assign ctrl_en  = st_reg.ctrl[RCO_OE_BIT];
	assign ctrl_slp = st_reg.ctrl[RCO_SLP_BIT];
	assign ctrl_sel = st_reg.ctrl[RCO_SEL_BIT];
	assign divisor  = st_reg.ctrl[RCO_DIV_LSB +: RCO_DIV_W];
	assign wr_div   = hwdata[RCO_DIV_LSB +: RCO_DIV_W];
	assign running  = (st_reg.fsm == RCO_RUN) || (st_reg.fsm == RCO_SLEEP_RUN);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero wait states, so the bus never stalls on this block
	assign hreadyout  = 1'b1;
	assign hresp      = RCO_HRESP_OKAY;
	assign hrdata     = st_reg.rdata;
	assign addr_phase = hsel && (htrans == RCO_HTRANS_NONSEQ) && hready;
	assign ctrl_wr    = st_reg.dp_write && st_reg.dp_ctrl;

	always_comb begin
		status                   = '0;
		status[RCO_ST_PIN_BIT]   = st_reg.pin;
		status[RCO_ST_RUN_BIT]   = running;
		status[RCO_ST_PDN_BIT]   = primary_osc_power_down;
		status[RCO_ST_FSM_LSB +: 2] = st_reg.fsm;
		status[RCO_ST_ALLOW_BIT] = sleep_allowed;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// Narrow writes are ignored rather than merged into the register
		st_next.dp_write = addr_phase && hwrite && (hsize == RCO_HSIZE_WORD);
		st_next.dp_ctrl  = (haddr == RCO_CTRL_OFFSET);
		// divisor is written with the rest
		if (ctrl_wr) begin
			st_next.ctrl = hwdata[RCO_REG_W-1:0] & RCO_CTRL_WMASK;
		end
		// Read data is taken from the next value so a write just before is seen
		st_next.rdata = 32'h0000_0000;
		if (addr_phase && !hwrite) begin
			case (haddr)
				RCO_CTRL_OFFSET: begin
					st_next.rdata[RCO_REG_W-1:0] = st_next.ctrl;
				end
				RCO_STAT_OFFSET: begin
					st_next.rdata[RCO_STAT_W-1:0] = status;
				end
				default: begin
					st_next.rdata = 32'h0000_0000;
				end
			endcase
		end
		case (st_reg.fsm)
			RCO_OFF: begin
				if (ctrl_en) begin
					if (!sleep_mode) begin
						st_next.fsm = RCO_RUN;
					end else if (sleep_allowed) begin
						st_next.fsm = RCO_SLEEP_RUN;
					end else begin
						st_next.fsm = RCO_HALT;
					end
				end
			end
			RCO_RUN: begin
				if (!ctrl_en) begin
					st_next.fsm = RCO_OFF;
				end else if (sleep_mode) begin
					st_next.fsm = sleep_allowed ? RCO_SLEEP_RUN : RCO_HALT;
				end
			end
			RCO_SLEEP_RUN: begin
				if (!ctrl_en) begin
					st_next.fsm = RCO_OFF;
				end else if (!sleep_mode) begin
					st_next.fsm = RCO_RUN;
				end else if (!sleep_allowed) begin
					st_next.fsm = RCO_HALT;
				end
			end
			RCO_HALT: begin
				if (!ctrl_en) begin
					st_next.fsm = RCO_OFF;
				end else if (!sleep_mode) begin
					st_next.fsm = RCO_RUN;
				end else if (sleep_allowed) begin
					st_next.fsm = RCO_SLEEP_RUN;
				end
			end
			default: begin
				st_next.fsm = RCO_OFF;
			end
		endcase
		st_next.pin_oe = ctrl_en;
		st_next.pin    = ctrl_en && running && div_out;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg      <= '0;
			st_reg.ctrl <= RCO_CTRL_RESET;
			st_reg.fsm  <= RCO_OFF;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reference_clock_pin    = st_reg.pin;
	assign reference_clock_pin_oe = st_reg.pin_oe;

	// ----------------------------------------------------------------
	// Base clock and divider
	// ----------------------------------------------------------------
	rco_source_gate rco_source_gate_i (
		.hclk                   (hclk),
		.hresetn                (hresetn),
		.source_select          (ctrl_sel),
		.sleep_run              (ctrl_slp),
		.sleep_mode             (sleep_mode),
		.primary_osc_mode       (primary_osc_mode),
		.primary_osc_tick       (primary_osc_tick),
		.system_clk_tick        (system_clk_tick),
		.base_tick              (base_tick),
		.sleep_allowed          (sleep_allowed),
		.primary_osc_power_down (primary_osc_power_down)
	);

	// restart on every control write avoids runt pulses at a divisor change
	rco_divider rco_divider_i (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.base_tick      (base_tick),
		.run            (running),
		.restart        (ctrl_wr),
		.divisor_select (divisor),
		.div_out        (div_out)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	pin_oe_on_a: assert property (
		ctrl_en |=> reference_clock_pin_oe)
		else $error("Pin enable did not follow the enable bit");
	pin_off_a: assert property (
		!ctrl_en |=> !reference_clock_pin_oe && !reference_clock_pin)
		else $error("Pin still active with the enable bit clear");
	div_field_a: assert property (
		ctrl_wr |=> divisor == $past(wr_div))
		else $error("Divisor field did not take the written value");
	src_primary_a: assert property (
		ctrl_sel && !primary_osc_tick |-> !base_tick)
		else $error("Base tick seen without a primary oscillator tick");
	src_system_a: assert property (
		!ctrl_sel && !system_clk_tick |-> !base_tick)
		else $error("Base tick seen without a system clock tick");
	sleep_stop_a: assert property (
		sleep_mode && !ctrl_slp |=> !running)
		else $error("Output kept running in sleep with sleep-run clear");
	sleep_both_a: assert property (
		running && sleep_mode && $past(sleep_mode) |-> $past(ctrl_slp) && $past(ctrl_sel))
		else $error("Output ran in sleep without both bits set");
	sleep_mode_a: assert property (
		st_reg.fsm == RCO_SLEEP_RUN |-> $past(primary_osc_mode) != RCO_OSC_INTERNAL)
		else $error("Sleep output ran without a primary oscillator mode");
	osc_down_a: assert property (
		sleep_mode && !ctrl_sel |=> primary_osc_power_down)
		else $error("Primary oscillator not powered down in sleep");
	awake_run_a: assert property (
		ctrl_en && !sleep_mode |=> running)
		else $error("Enabled output not running while awake");
	osc_keep_a: assert property (
		ctrl_sel |=> !primary_osc_power_down)
		else $error("Selected primary oscillator was powered down");
	rdata_ctrl_a: assert property (
		addr_phase && !hwrite && (haddr == RCO_CTRL_OFFSET) && !ctrl_wr
		|=> hrdata[RCO_REG_W-1:0] == st_reg.ctrl)
		else $error("Control read returned a stale value");

	// ----------------------------------------------------------------
	// Bus and pin checks
	// ----------------------------------------------------------------
	// Read data stands for the data phase only, so stale words never linger
	rdata_idle_a: assert property (
		!(addr_phase && !hwrite) |=> hrdata == 32'h0000_0000)
		else $error("Read data not cleared outside a read");
	rdata_stat_a: assert property (
		addr_phase && !hwrite && (haddr == RCO_STAT_OFFSET)
		|=> hrdata[RCO_STAT_W-1:0] == $past(status))
		else $error("Status read returned a stale value");
	rdata_hole_a: assert property (
		addr_phase && !hwrite && (haddr != RCO_CTRL_OFFSET) && (haddr != RCO_STAT_OFFSET)
		|=> hrdata == 32'h0000_0000)
		else $error("Unmapped read returned nonzero data");
	// Narrow or misdirected writes must never reach the control word
	narrow_wr_a: assert property (
		addr_phase && hwrite && (hsize != RCO_HSIZE_WORD) |=> !ctrl_wr)
		else $error("Narrow write reached the control register");
	other_wr_a: assert property (
		addr_phase && hwrite && (haddr != RCO_CTRL_OFFSET) |=> !ctrl_wr)
		else $error("Write to another address reached the control register");

	// Halted in sleep keeps the pin driven low rather than released
	halt_pin_a: assert property (
		st_reg.fsm == RCO_HALT |=> !reference_clock_pin)
		else $error("Pin toggled while halted in sleep");
	pin_rise_a: assert property (
		$rose(reference_clock_pin) |-> $past(running) && $past(ctrl_en))
		else $error("Pin rose while the output was not running");

	sleep_run_c: cover property (st_reg.fsm == RCO_SLEEP_RUN && base_tick);
	halt_c: cover property (st_reg.fsm == RCO_HALT);
	max_div_c: cover property (ctrl_wr && (wr_div == 4'hF));
	pin_rise_c: cover property ($rose(reference_clock_pin));
	// Wake from a halted sleep back into normal running
	halt_exit_c: cover property (st_reg.fsm == RCO_HALT ##1 st_reg.fsm == RCO_RUN);

endmodule : rco_refclk_out

// >>> rtl/rco_pkg.sv
/*
 * Shared constants and types for the reference clock output divider.
 * Assumes a single 40 MHz bus clock; the base clocks arrive as enable ticks on it.
 */
package rco_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] RCO_CTRL_OFFSET = 32'h0000_0000;
	localparam logic [31:0] RCO_STAT_OFFSET = 32'h0000_0004;
	localparam int          RCO_REG_W       = 16;
	localparam logic [15:0] RCO_CTRL_RESET  = 16'h0000;
	// Only the enable, sleep-run, source and divisor bits are writable
	localparam logic [15:0] RCO_CTRL_WMASK  = 16'hBF00;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int RCO_OE_BIT  = 15;
	localparam int RCO_SLP_BIT = 13;
	localparam int RCO_SEL_BIT = 12;
	localparam int RCO_DIV_LSB = 8;
	localparam int RCO_DIV_W   = 4;
	localparam int RCO_TAPS    = 16;
	localparam int RCO_CNT_W   = 15;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int RCO_ST_PIN_BIT   = 0;
	localparam int RCO_ST_RUN_BIT   = 1;
	localparam int RCO_ST_PDN_BIT   = 2;
	localparam int RCO_ST_FSM_LSB   = 3;
	localparam int RCO_ST_ALLOW_BIT = 5;
	localparam int RCO_STAT_W       = 6;

	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] RCO_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] RCO_HSIZE_WORD    = 3'h2;
	localparam logic       RCO_HRESP_OKAY    = 1'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RCO_OSC_INTERNAL                = 2'h0,
		RCO_EXTERNAL_CLOCK_PRIMARY_MODE = 2'h1,
		RCO_HIGH_SPEED_CRYSTAL_MODE     = 2'h2,
		RCO_STANDARD_CRYSTAL_MODE       = 2'h3
	} rco_osc_mode_t;

	typedef enum logic [1:0] {
		RCO_OFF       = 2'h0,
		RCO_RUN       = 2'h1,
		RCO_SLEEP_RUN = 2'h3,
		RCO_HALT      = 2'h2
	} rco_state_t;

endpackage : rco_pkg

// >>> rtl/rco_source_gate.sv
/*
 * Base clock selection and primary oscillator sleep control.
 * Assumes both base clocks arrive as one-cycle ticks synchronous to hclk.
 */
`timescale 1ns/1ps
module rco_source_gate (
	input  logic                   hclk,
	input  logic                   hresetn,
	input  logic                   source_select,
	input  logic                   sleep_run,
	input  logic                   sleep_mode,
	input  rco_pkg::rco_osc_mode_t primary_osc_mode,
	input  logic                   primary_osc_tick,
	input  logic                   system_clk_tick,
	output logic                   base_tick,
	output logic                   sleep_allowed,
	output logic                   primary_osc_power_down
);
	import rco_pkg::*;

	typedef struct packed {
		logic pdn;
	} rco_gate_t;

	rco_gate_t st_reg;
	rco_gate_t st_next;

	assign base_tick = source_select ? primary_osc_tick : system_clk_tick;

	assign sleep_allowed = sleep_run && source_select && (primary_osc_mode != RCO_OSC_INTERNAL);

	always_comb begin
		st_next = st_reg;
		st_next.pdn = sleep_mode && !source_select;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign primary_osc_power_down = st_reg.pdn;

endmodule : rco_source_gate

// >>> rtl/rco_divider.sv
/*
 * Power-of-two divider on the base clock ticks.
 * Assumes the caller restarts it whenever the divisor code changes.
 */
`timescale 1ns/1ps
module rco_divider (
	input  logic       hclk,
	input  logic       hresetn,
	input  logic       base_tick,
	input  logic       run,
	input  logic       restart,
	input  logic [3:0] divisor_select,
	output logic       div_out
);
	import rco_pkg::*;

	typedef struct packed {
		logic [RCO_CNT_W-1:0] cnt;
		logic                 out;
	} rco_div_t;

	rco_div_t             st_reg;
	rco_div_t             st_next;
	logic [RCO_CNT_W-1:0] cnt_inc;
	logic [RCO_TAPS-1:0]  taps;

	assign cnt_inc = st_reg.cnt + 15'h0001;

	// counter bit n-1 gives divide by 2^n
	assign taps[0] = 1'b1;
	for (genvar k = 1; k < RCO_TAPS; k++) begin : g_tap
		assign taps[k] = cnt_inc[k-1];
	end

	always_comb begin
		st_next = st_reg;
		if (restart || !run) begin
			st_next.cnt = '0;
			st_next.out = 1'b0;
		end else if (base_tick) begin
			st_next.cnt = cnt_inc;
			st_next.out = taps[divisor_select];
		end else if (divisor_select == 4'h0) begin
			st_next.out = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign div_out = st_reg.out;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	div_two_a: assert property (
		(divisor_select == 4'h1) && run && base_tick && !restart |=> div_out != $past(div_out))
		else $error("Divide by two did not toggle on a tick");
	div_max_a: assert property (
		(divisor_select == 4'hF) && run && !restart && $rose(div_out) |-> st_reg.cnt == 15'h4000)
		else $error("Divide by 32768 rose at the wrong count");
	div_pass_a: assert property (
		(divisor_select == 4'h0) && run && !restart |=> div_out == $past(base_tick))
		else $error("Undivided output did not follow the base tick");
	div_stop_a: assert property (
		!run || restart |=> !div_out && (st_reg.cnt == 15'h0000))
		else $error("Divider did not clear when stopped");

endmodule : rco_divider

// >>> verification/rco_ext_load.sv
/*
 * Model of an external load clocked from the reference clock pin.
 * Assumes the pin is sampled on hclk; a pull-down holds the line low when not driven.
 */
`timescale 1ns/1ps
module rco_ext_load (
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        pin,
	input  logic        pin_oe,
	output logic [16:0] period,
	output logic [16:0] hi_len,
	output logic [31:0] rises
);
	// ----------------------------------------------------------------
	// Edge measurement
	// ----------------------------------------------------------------
	logic        seen;
	logic        last;
	logic [16:0] run_cnt;
	logic [16:0] hi_cnt;

	// Undriven line falls to the pull-down level
	assign seen = pin_oe & pin;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last    <= 1'b0;
			run_cnt <= 17'h0_0000;
			hi_cnt  <= 17'h0_0000;
			period  <= 17'h0_0000;
			hi_len  <= 17'h0_0000;
			rises   <= 32'h0000_0000;
		end else begin
			last    <= seen;
			run_cnt <= run_cnt + 17'h0_0001;
			if (seen)
				hi_cnt <= hi_cnt + 17'h0_0001;
			if (seen && !last) begin
				period  <= run_cnt;
				run_cnt <= 17'h0_0001;
				hi_cnt  <= 17'h0_0001;
				rises   <= rises + 32'h0000_0001;
			end
			if (!seen && last)
				hi_len <= hi_cnt;
		end
	end
endmodule : rco_ext_load

// >>> verification/tb_top.sv
/*
 * Testbench for the reference clock output: AHB-Lite register access and pin checks.
 * Assumes the system tick runs every hclk cycle unless slowed, the primary tick every second one.
 */
`timescale 1ns/1ps
module tb_top;
	import rco_pkg::*;

	logic                 hclk;
	logic                 hresetn;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [2:0]           hsize;
	logic [31:0]          hwdata;
	logic                 hreadyout;
	logic                 hresp;
	logic [31:0]          hrdata;
	logic                 sleep_mode;
	rco_osc_mode_t        osc_mode;
	logic                 p_tick = 1'b0;
	logic                 s_tick = 1'b1;
	logic                 s_slow = 1'b0;
	logic                 pin;
	logic                 pin_oe;
	logic                 pdn;
	logic [16:0]          period;
	logic [16:0]          hi_len;
	logic [31:0]          rises;
	int                   n_fail;
	int                   samples_checked;
	int                   cyc = 0;

	rco_refclk_out rco_refclk_out_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sleep_mode(sleep_mode), .primary_osc_mode(osc_mode),
		.primary_osc_tick(p_tick), .system_clk_tick(s_tick),
		.reference_clock_pin(pin), .reference_clock_pin_oe(pin_oe),
		.primary_osc_power_down(pdn)
	);

	rco_ext_load rco_ext_load_i (
		.hclk(hclk), .hresetn(hresetn), .pin(pin), .pin_oe(pin_oe),
		.period(period), .hi_len(hi_len), .rises(rises)
	);

	// ----------------------------------------------------------------
	// Clock, ticks and timeout
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Longest check is two periods of the divide-by-32768 tap
	always @(posedge hclk) begin
		p_tick <= ~p_tick;
		// A tick on every cycle cannot show an undivided pulse train
		s_tick <= s_slow ? ~s_tick : 1'b1;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [2:0] sz, input logic [31:0] a,
			input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= RCO_HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= sz;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(32'(hresp), 32'(RCO_HRESP_OKAY));
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, RCO_HSIZE_WORD, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, RCO_HSIZE_WORD, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask : rd_chk

	// Period and high time in hclk cycles for one divisor code and source
	task automatic div_chk(input logic [3:0] code, input logic src, input int tk);
		int per;
		int hi;
		per = (code == 4'h0) ? tk : (2 ** code) * tk;
		hi = (code == 4'h0) ? 1 : (2 ** code) * tk / 2;
		wr(RCO_CTRL_OFFSET, 32'h0000_8000 | (32'(src) << 12) | (32'(code) << 8));
		repeat (2 * per + 20) @(posedge hclk);
		chk(32'(period), 32'(per));
		chk(32'(hi_len), 32'(hi));
	endtask : div_chk

	task automatic run_chk(input logic exp);
		logic [31:0] r0;
		// Let state and pin settle so a last edge of the old setting is not counted
		repeat (4) @(posedge hclk);
		r0 = rises;
		repeat (40) @(posedge hclk);
		chk(32'(rises != r0), 32'(exp));
	endtask : run_chk

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = RCO_HSIZE_WORD;
		hwdata = 32'h0000_0000;
		sleep_mode = 1'b0;
		osc_mode = RCO_EXTERNAL_CLOCK_PRIMARY_MODE;
		n_fail = 0;
		samples_checked = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(RCO_CTRL_OFFSET, 32'h0000_0000);
		chk(32'(pin_oe), 32'h0000_0000);
		wr(RCO_CTRL_OFFSET, 32'hFFFF_FFFF);
		rd_chk(RCO_CTRL_OFFSET, 32'h0000_BF00);
		chk(32'(pin_oe), 32'h0000_0001);
		// Byte-sized writes must leave the control word alone
		ahb(1'b1, 3'h0, RCO_CTRL_OFFSET, 32'h0000_0000, r);
		rd_chk(RCO_CTRL_OFFSET, 32'h0000_BF00);
		rd_chk(32'h0000_0010, 32'h0000_0000);
		for (int n = 1; n < 7; n++)
			div_chk(4'(n), 1'b0, 1);
		div_chk(4'h1, 1'b1, 2);
		div_chk(4'h0, 1'b1, 2);
		s_slow <= 1'b1;
		div_chk(4'h0, 1'b0, 2);
		s_slow <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			osc_mode <= rco_osc_mode_t'(m);
			div_chk(4'h2, 1'b0, 1);
		end
		wr(RCO_CTRL_OFFSET, 32'h0000_B200);
		sleep_mode <= 1'b1;
		for (int m = 1; m < 4; m++) begin
			osc_mode <= rco_osc_mode_t'(m);
			run_chk(1'b1);
			chk(32'(pdn), 32'h0000_0000);
		end
		osc_mode <= RCO_OSC_INTERNAL;
		run_chk(1'b0);
		osc_mode <= RCO_STANDARD_CRYSTAL_MODE;
		wr(RCO_CTRL_OFFSET, 32'h0000_9200);
		run_chk(1'b0);
		wr(RCO_CTRL_OFFSET, 32'h0000_A200);
		run_chk(1'b0);
		chk(32'(pdn), 32'h0000_0001);
		rd_chk(RCO_STAT_OFFSET, (32'h0000_0001 << RCO_ST_PDN_BIT) | (32'h0000_0002 << RCO_ST_FSM_LSB));
		sleep_mode <= 1'b0;
		run_chk(1'b1);
		chk(32'(pdn), 32'h0000_0000);
		wr(RCO_CTRL_OFFSET, 32'h0000_0200);
		run_chk(1'b0);
		chk(32'(pin_oe), 32'h0000_0000);
		div_chk(4'hF, 1'b0, 1);
		report_and_stop();
	end
endmodule : tb_top
